// ---- pkg/ppi_consts.vh ----
/*
 * constants for the parallel pixel input port: channel layout, swap
 * codes, timing of the pixel clock and buffer depth.
 * assumes inclusion by bare name from core files.
 */
`ifndef PPI_CONSTS_VH
`define PPI_CONSTS_VH

// channel width: bit 9 weighs 128, bit 0 weighs 0.25
`define PPI_CHAN_W 10
`define PPI_INT_BITS 8
`define PPI_FRAC_BITS 2
`define PPI_PIX_W 30
// sync and control word: field, vsync, hsync
`define PPI_CTL_W 3
`define PPI_WORD_W 33
// channel order selects
`define PPI_SWAP_W 3
`define PPI_SWAP_ABC 3'h0
`define PPI_SWAP_ACB 3'h1
`define PPI_SWAP_BAC 3'h2
`define PPI_SWAP_BCA 3'h3
`define PPI_SWAP_CAB 3'h4
`define PPI_SWAP_CBA 3'h5
// source select for shared pins
`define PPI_SRC_W 2
`define PPI_SRC_NONE 2'h0
`define PPI_SRC_ZERO 2'h1
`define PPI_SRC_ONE 2'h2
`define PPI_SRC_RST 2'h1
// clock and link timing, ns
`define PPI_CLK_NS 100
`define PPI_LINK_NS 800
`define PPI_SYNC_STAGES 2
`define PPI_BUF_DEPTH 2

`endif

// ---- core/ppi_skid_buf.v ----
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes one clock, asynchronous active-high reset.
 */
`timescale 1ns/1ps
`include "ppi_consts.vh"

module ppi_skid_buf #(
    parameter W = `PPI_WORD_W
) (
    input wire clk,
    input wire sys_rst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

reg [W-1:0] mem_r [0:1];
reg wr_ptr_r;
reg rd_ptr_r;
reg [1:0] count_r;
wire push;
wire pop;

assign in_ready = (count_r != 2'h2);
assign out_valid = (count_r != 2'h0);
assign out_data = mem_r[rd_ptr_r];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (push) begin
        mem_r[wr_ptr_r] <= in_data;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        wr_ptr_r <= 1'b0;
        rd_ptr_r <= 1'b0;
        count_r <= 2'h0;
    end else begin
        if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
        end
        if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
        end
        case ({push, pop})
            2'b10: count_r <= count_r + 2'h1;
            2'b01: count_r <= count_r - 2'h1;
            default: count_r <= count_r;
        endcase
    end
end

endmodule // ppi_skid_buf

// ---- core/ppi_port.v ----
/*
 * parallel pixel input port: samples three 10-bit channels and syncs
 * on rising edges of pixel clock a, reorders channels, buffers words.
 * assumes pix_clk_a well below clk/2 (800 ns vs 100 ns in the bench);
 * all pin inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
`include "ppi_consts.vh"

// Functional notes
// RL1 - Vertical and horizontal sync are sampled on pixel clock a edges.
// RL2 - The source drives field sync only for interlaced video.
// RL3 - Each channel is ten bits weighted 128 down to 0.25.
// RL4 - All three channels are sampled on pixel clock a only.
// RL5 - Narrow sources are justified to the top, low bits zero.
// RL6 - An eight or ten bit serial-style source sits at the top of a channel.
// RL7 - The three channels can be reordered internally in any order.
// RL8 - A select drives enables that tri-state the unused shared source.
// RL9 - Only samples with data enable high are passed as pixels.
module ppi_port (
    input wire clk,
    input wire sys_rst,
    input wire pix_clk_a,
    input wire pix_clk_b,
    input wire pix_clk_c,
    input wire vert_sync_in,
    input wire horiz_sync_in,
    input wire pixel_valid_in,
    input wire interlace_field_in,
    input wire [`PPI_CHAN_W-1:0] chan_first_in,
    input wire [`PPI_CHAN_W-1:0] chan_second_in,
    input wire [`PPI_CHAN_W-1:0] chan_third_in,
    input wire [`PPI_SWAP_W-1:0] chan_order_sel,
    input wire interlaced_mode,
    input wire [`PPI_SRC_W-1:0] source_sel,
    output reg src0_output_en_n,
    output reg src1_output_en_n,
    output wire pix_out_valid,
    input wire pix_out_ready,
    output wire [`PPI_CHAN_W-1:0] pix_out_first,
    output wire [`PPI_CHAN_W-1:0] pix_out_second,
    output wire [`PPI_CHAN_W-1:0] pix_out_third,
    output wire vert_sync_out,
    output wire horiz_sync_out,
    output wire field_out,
    output reg ctl_valid,
    output reg overrun
);

localparam SW = `PPI_PIX_W + `PPI_CTL_W + 1;

reg [SW-1:0] meta_r;
reg [SW-1:0] sync_r;
reg clk_meta_r;
reg clk_sync_r;
reg clk_prev_r;
wire [SW-1:0] raw;
wire clk_rise;
wire [`PPI_CHAN_W-1:0] s_a;
wire [`PPI_CHAN_W-1:0] s_b;
wire [`PPI_CHAN_W-1:0] s_c;
reg [`PPI_CHAN_W-1:0] o_a;
reg [`PPI_CHAN_W-1:0] o_b;
reg [`PPI_CHAN_W-1:0] o_c;
reg [`PPI_WORD_W-1:0] word_r;
reg word_valid_r;
reg [`PPI_CTL_W-1:0] ctl_r;
reg [`PPI_WORD_W-1:0] word_nxt;
reg word_valid_nxt;
reg [`PPI_CTL_W-1:0] ctl_nxt;
reg overrun_nxt;
reg src0_output_en_n_nxt;
reg src1_output_en_n_nxt;
wire field_seen;
wire take_pixel;
wire stage_stuck;
wire buf_in_ready;
wire [`PPI_WORD_W-1:0] buf_out;

////////////////////////////////////////////////////////////////////////
// two-stage synchronisers; clocks b and c are unused by sampling
assign raw = {pixel_valid_in, interlace_field_in, vert_sync_in,
              horiz_sync_in, chan_first_in, chan_second_in,
              chan_third_in};

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        meta_r <= {SW{1'b0}};
        sync_r <= {SW{1'b0}};
    end else begin
        meta_r <= raw;
        sync_r <= meta_r;
    end
end

// pixel clock a: two stages, then one more for edge finding
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        clk_meta_r <= 1'b0;
        clk_sync_r <= 1'b0;
        clk_prev_r <= 1'b0;
    end else begin
        clk_meta_r <= pix_clk_a; // RL4
        clk_sync_r <= clk_meta_r;
        clk_prev_r <= clk_sync_r;
    end
end

// data lags the clock edge by the same two stages, so sync_r holds the
// value present at the pixel clock a rising edge
assign clk_rise = clk_sync_r && !clk_prev_r; // RL1 RL4

// channels kept as 8.2 fixed point, no rescaling of narrow sources
assign s_a = sync_r[3*`PPI_CHAN_W-1:2*`PPI_CHAN_W]; // RL3 RL5 RL6
assign s_b = sync_r[2*`PPI_CHAN_W-1:`PPI_CHAN_W];
assign s_c = sync_r[`PPI_CHAN_W-1:0];

////////////////////////////////////////////////////////////////////////
// channel reorder
always @* begin
    case (chan_order_sel) // RL7
        `PPI_SWAP_ACB: begin o_a = s_a; o_b = s_c; o_c = s_b; end
        `PPI_SWAP_BAC: begin o_a = s_b; o_b = s_a; o_c = s_c; end
        `PPI_SWAP_BCA: begin o_a = s_b; o_b = s_c; o_c = s_a; end
        `PPI_SWAP_CAB: begin o_a = s_c; o_b = s_a; o_c = s_b; end
        `PPI_SWAP_CBA: begin o_a = s_c; o_b = s_b; o_c = s_a; end
        default: begin o_a = s_a; o_b = s_b; o_c = s_c; end
    endcase
end

////////////////////////////////////////////////////////////////////////
// capture: sync state always tracked, pixels only with data enable
// field ignored for progressive sources
assign field_seen = interlaced_mode && sync_r[SW-2]; // RL2
assign take_pixel = clk_rise && sync_r[SW-1]; // RL9
assign stage_stuck = word_valid_r && !buf_in_ready;

always @* begin
    ctl_nxt = ctl_r;
    word_nxt = word_r;
    word_valid_nxt = word_valid_r;
    overrun_nxt = overrun;
    if (clk_rise) begin
        ctl_nxt = {field_seen, sync_r[SW-3], sync_r[SW-4]}; // RL1 RL2
    end
    if (word_valid_r && buf_in_ready) begin
        word_valid_nxt = 1'b0;
    end
    if (take_pixel) begin // RL9
        // a pending word that could not move on is overwritten
        word_nxt = {field_seen, sync_r[SW-3], sync_r[SW-4], o_a, o_b, o_c};
        word_valid_nxt = 1'b1;
        overrun_nxt = overrun || stage_stuck;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        word_r <= {`PPI_WORD_W{1'b0}};
        word_valid_r <= 1'b0;
        ctl_r <= {`PPI_CTL_W{1'b0}};
        ctl_valid <= 1'b0;
        overrun <= 1'b0;
    end else begin
        word_r <= word_nxt;
        word_valid_r <= word_valid_nxt;
        ctl_r <= ctl_nxt;
        ctl_valid <= clk_rise;
        overrun <= overrun_nxt;
    end
end

assign vert_sync_out = ctl_r[1];
assign horiz_sync_out = ctl_r[0];
assign field_out = ctl_r[2];

ppi_skid_buf #(
    .W(`PPI_WORD_W)
) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(word_valid_r),
    .in_ready(buf_in_ready),
    .in_data(word_r),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data(buf_out)
);

assign pix_out_first = buf_out[3*`PPI_CHAN_W-1:2*`PPI_CHAN_W];
assign pix_out_second = buf_out[2*`PPI_CHAN_W-1:`PPI_CHAN_W];
assign pix_out_third = buf_out[`PPI_CHAN_W-1:0];

////////////////////////////////////////////////////////////////////////
// shared-pin source control, enables active low
// at most one source enabled; unknown codes float both
always @* begin
    src0_output_en_n_nxt = 1'b1;
    src1_output_en_n_nxt = 1'b1;
    case (source_sel) // RL8
        `PPI_SRC_ZERO: src0_output_en_n_nxt = 1'b0;
        `PPI_SRC_ONE: src1_output_en_n_nxt = 1'b0;
        default: begin
            src0_output_en_n_nxt = 1'b1;
            src1_output_en_n_nxt = 1'b1;
        end
    endcase
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        src0_output_en_n <= 1'b1;
        src1_output_en_n <= 1'b1;
    end else begin
        src0_output_en_n <= src0_output_en_n_nxt; // RL8
        src1_output_en_n <= src1_output_en_n_nxt; // RL8
    end
end

endmodule // ppi_port

// ---- tb/ppi_port_checker.sv ----
/* timing checks on the pixel port outputs.
   assumes the clk domain only and sys_rst async, active high. */
`timescale 1ns/1ps
`include "ppi_consts.vh"
module ppi_chk (
    input wire clk,
    input wire sys_rst,
    input wire pix_clk_a,
    input wire [`PPI_SRC_W-1:0] source_sel,
    input wire src0_output_en_n,
    input wire src1_output_en_n,
    input wire pix_out_valid,
    input wire pix_out_ready,
    input wire [`PPI_CHAN_W-1:0] pix_out_first,
    input wire vert_sync_out,
    input wire horiz_sync_out,
    input wire ctl_valid
);
default clocking dc @(posedge clk); endclocking
default disable iff (sys_rst);
property p_sync_tie;
    $changed(vert_sync_out) || $changed(horiz_sync_out) |-> ctl_valid;
endproperty
a_sync_tie: assert property (p_sync_tie) else $error("sync moved");
property p_take;
    $rose(pix_clk_a) |-> ##[2:5] ctl_valid;
endproperty
a_take: assert property (p_take) else $error("clock a rise not taken");
property p_pix;
    $rose(pix_out_valid) |-> $past(ctl_valid);
endproperty
a_pix: assert property (p_pix) else $error("pixel without a take");
property p_hold;
    pix_out_valid && !pix_out_ready |=>
        pix_out_valid && $stable(pix_out_first);
endproperty
a_hold: assert property (p_hold) else $error("stalled pixel lost");
property p_src;
    source_sel == `PPI_SRC_ZERO |=> !src0_output_en_n && src1_output_en_n;
endproperty
a_src: assert property (p_src) else $error("source zero not enabled");
property p_src1;
    source_sel == `PPI_SRC_ONE |=> src0_output_en_n && !src1_output_en_n;
endproperty
a_src1: assert property (p_src1) else $error("source one not enabled");
property p_excl;
    src0_output_en_n || src1_output_en_n;
endproperty
a_excl: assert property (p_excl) else $error("both sources driving");
c_take: cover property (ctl_valid);
c_pop: cover property (pix_out_valid && pix_out_ready);
c_one: cover property (!src1_output_en_n);
endmodule // ppi_chk
bind ppi_port ppi_chk i_chk (.clk(clk), .sys_rst(sys_rst),
    .pix_clk_a(pix_clk_a), .source_sel(source_sel),
    .src0_output_en_n(src0_output_en_n), .src1_output_en_n(src1_output_en_n),
    .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
    .pix_out_first(pix_out_first), .vert_sync_out(vert_sync_out),
    .horiz_sync_out(horiz_sync_out), .ctl_valid(ctl_valid));

// ---- tb/ppi_src_model.sv ----
/* video source model: one pixel per call, clock a still between calls.
   assumes pulldowns on every pin, so released lines read 0. */
`timescale 1ns/1ps
module ppi_src (
    input wire en_n,
    output wire clk_a,
    output wire [33:0] pins
);
reg [33:0] q;
reg ck;
initial begin
    q = 34'h0;
    ck = 1'b0;
end
assign clk_a = ck & ~en_n;
assign pins = en_n ? 34'h0 : q;
// word is {field, enable, vsync, hsync, first, second, third}
task send(input [33:0] w);
    begin
        q = w;
        #400 ck = 1'b1;
        #400 ck = 1'b0;
    end
endtask
endmodule // ppi_src

// ---- tb/tb.sv ----
/* scenario bench for the pixel port.
   assumes the source model drives pins and clock a at 800 ns. */
`timescale 1ns/1ps
`include "ppi_consts.vh"
module tb;
reg clk = 0;
reg sys_rst = 1;
reg [2:0] osel = 0;
reg imode = 0;
reg [1:0] ssel = `PPI_SRC_ZERO;
reg rdy = 0;
wire pa, s0n, s1n, pv, vs, hs, fo, cv, ovr;
wire [33:0] p;
wire [9:0] o1, o2, o3;
integer bad_count = 0;
integer checks_done = 0;
integer k;
reg [95:0] tbl = {12'h123, 12'h132, 12'h213, 12'h231, 12'h312, 12'h321,
                  12'h123, 12'h123};
reg [95:0] t;
always #50 clk = ~clk;
ppi_src m_src (.en_n(s0n), .clk_a(pa), .pins(p));
ppi_port i_ppi_port (.clk(clk), .sys_rst(sys_rst), .pix_clk_a(pa),
    .pix_clk_b(~pa), .pix_clk_c(~pa), .vert_sync_in(p[31]),
    .horiz_sync_in(p[30]), .pixel_valid_in(p[32]),
    .interlace_field_in(p[33]), .chan_first_in(p[29:20]),
    .chan_second_in(p[19:10]), .chan_third_in(p[9:0]),
    .chan_order_sel(osel), .interlaced_mode(imode), .source_sel(ssel),
    .src0_output_en_n(s0n), .src1_output_en_n(s1n), .pix_out_valid(pv),
    .pix_out_ready(rdy), .pix_out_first(o1), .pix_out_second(o2),
    .pix_out_third(o3), .vert_sync_out(vs), .horiz_sync_out(hs),
    .field_out(fo), .ctl_valid(cv), .overrun(ovr));
task tick(input integer n);
    repeat (n) begin
        @(posedge clk);
        #1;
    end
endtask
task chk(input [33:0] s, input [33:0] e, input [63:0] nm);
    begin
        checks_done = checks_done + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, s);
        end
    end
endtask
task pop(input [29:0] e);
    integer n;
    begin
        n = 0;
        while (pv !== 1'b1 && n < 40) begin
            tick(1);
            n = n + 1;
        end
        chk({o1, o2, o3}, e, "pixel");
        rdy = 1;
        tick(1);
        rdy = 0;
        tick(1);
    end
endtask
task final_report;
    begin
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
task t_weight;
    begin
        m_src.send({4'h4, 10'h3FC, 10'h004, 10'h001});
        pop({10'h3FC, 10'h004, 10'h001});
    end
endtask
task t_swap;
    for (k = 0; k < 8; k = k + 1) begin
        osel = k[2:0];
        t = tbl >> (12 * (7 - k));
        m_src.send({4'h4, 10'h001, 10'h002, 10'h003});
        pop({6'h0, t[11:8], 6'h0, t[7:4], 6'h0, t[3:0]});
    end
endtask
task t_blank;
    begin
        m_src.send({4'h3, 30'h3FFFFFFF});
        tick(3);
        chk({pv, vs, hs}, 3'h3, "blank");
        m_src.send({4'h0, 30'h0});
        tick(3);
        chk({pv, vs, hs}, 3'h0, "sync");
    end
endtask
task t_field;
    begin
        imode = 1;
        m_src.send({4'h8, 30'h0});
        tick(3);
        chk(fo, 1'b1, "field");
        imode = 0;
        m_src.send({4'h8, 30'h0});
        tick(3);
        chk(fo, 1'b0, "field");
    end
endtask
task t_buf;
    begin
        for (k = 1; k < 4; k = k + 1)
            m_src.send({4'h4, 10'h0, 10'h0, k[9:0]});
        tick(4);
        chk(ovr, 1'b0, "overrun");
        for (k = 1; k < 4; k = k + 1)
            pop({20'h0, k[9:0]});
    end
endtask
task t_src;
    begin
        ssel = `PPI_SRC_ONE;
        tick(2);
        chk({s0n, s1n}, 2'h2, "enables");
        m_src.send({4'h4, 30'h1});
        tick(6);
        chk({pv, p[0]}, 2'h0, "released");
        ssel = `PPI_SRC_NONE;
        tick(2);
        chk({s0n, s1n}, 2'h3, "enables");
        ssel = 2'h3;
        tick(2);
        chk({s0n, s1n}, 2'h3, "enables");
    end
endtask
initial begin
    tick(20);
    chk({s0n, s1n, pv}, 3'h6, "reset");
    sys_rst = 0;
    tick(2);
    t_weight;
    t_swap;
    t_blank;
    t_field;
    t_buf;
    t_src;
    final_report;
end
initial begin
    #200000;
    bad_count = bad_count + 1;
    final_report;
end
endmodule // tb
